// file: shared/otp_write_strobe_a_pkg.sv
// package: constants and carriers for the otp programming port
package otp_write_strobe_a_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int LO_W = 8;
    localparam int HI_W = 6;
    localparam int MEM_DEPTH = 16384;
    localparam int VER_DEPTH = 4;
    localparam int VER_IDX_W = 2;
    localparam int LOCK_W = 2;
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_VERSION = 2'h1;
    localparam logic [1:0] SEL_LOCK = 2'h2;
    localparam logic [1:0] SEL_MEMORY = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] RESERVED_READ = 8'hFF;
    localparam logic [LOCK_W-1:0] LOCK_RESET = 2'h0;
    // version bytes: arbitrary neutral values
    localparam logic [DATA_W-1:0] VERSION_BYTE0 = 8'hA5;
    localparam logic [DATA_W-1:0] VERSION_BYTE1 = 8'h5A;
    localparam logic [DATA_W-1:0] VERSION_BYTE2 = 8'h01;
    localparam logic [DATA_W-1:0] VERSION_BYTE3 = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_ACTIVE = 4'h4,
        ST_LOCKED = 4'h8
    } mode_state_type;

    typedef struct packed {
        logic reset_in;
        logic program_store_enable;
        logic program_voltage_pin;
        logic entry_select;
        logic high_addr_latch_strobe;
        logic access_select_hi;
        logic access_select_lo;
        logic write_strobe_a_read_strobe_n;
        logic write_strobe_a_n;
    } ctrl_pins_type;

    typedef struct packed {
        logic [DATA_W-1:0] data_o;
        logic data_oe;
    } data_drive_type;
endpackage

// file: src/otp_edge_detect.sv
// falling and rising edge detector for one synchronous pin
`timescale 1ns/1ps
module otp_edge_detect #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level_in,
    output logic fall,
    output logic rise,
    output logic level_q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // must equal the pin's idle level, or a false edge follows reset
            level_q <= RESET_LEVEL;
        end else begin
            level_q <= level_in;
        end
    end
    assign fall = level_q & ~level_in;
    assign rise = ~level_q & level_in;
endmodule

// file: src/otp_programming_port.sv
// otp programming port: slave memory interface in programming mode
// Functional notes
// - in programming mode the device is a pure slave, driven only by pins.
// - port 0 is bidirectional data, port 2 is multiplexed address input.
// - high address on port 2 latched at falling edge of latch strobe.
// - access select 00 reserved, 01 version, 10 lock bits, 11 memory byte.
// - read strobe gates all reads; selected data driven while strobe asserted.
// - entry select stays low after falling; states latched at that edge.
// - write strobe programs memory bytes and writes lock bits.
// - once protected and mode exited, programming mode entry is refused.
`timescale 1ns/1ps
module otp_programming_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire otp_write_strobe_a_pkg::ctrl_pins_type pins,
    input wire logic [otp_write_strobe_a_pkg::LO_W-1:0] addr_port,
    input wire logic [otp_write_strobe_a_pkg::DATA_W-1:0] data_in,
    output logic [otp_write_strobe_a_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic write_strobe_a_mode,
    output logic prot_locked
);
    otp_write_strobe_a_pkg::mode_state_type state_q, state_d;
    logic [otp_write_strobe_a_pkg::DATA_W-1:0] mem [otp_write_strobe_a_pkg::MEM_DEPTH] = '{default: otp_write_strobe_a_pkg::ERASED_BYTE};
    logic [otp_write_strobe_a_pkg::HI_W-1:0] hi_addr_q;
    logic [otp_write_strobe_a_pkg::LOCK_W-1:0] lock_q;
    logic vpp_mode_q;
    logic [otp_write_strobe_a_pkg::DATA_W-1:0] rd_data_q;
    logic entry_fall;
    logic latch_fall;
    logic wr_rise;

    otp_edge_detect u_entry (.clk(clk), .rst_n(rst_n), .level_in(pins.entry_select),
        .fall(entry_fall), .rise(), .level_q());
    otp_edge_detect u_latch (.clk(clk), .rst_n(rst_n), .level_in(pins.high_addr_latch_strobe),
        .fall(latch_fall), .rise(), .level_q());
    // write strobe idles high; a low reset value would fake a write edge just after reset
    otp_edge_detect #(.RESET_LEVEL(1'b1)) u_write (.clk(clk), .rst_n(rst_n),
        .level_in(pins.write_strobe_a_n), .fall(), .rise(wr_rise), .level_q());

    // entry conditions checked in idle state, before arming
    wire arm_ok = pins.reset_in && !pins.program_store_enable && !pins.write_strobe_a_n
        && !pins.high_addr_latch_strobe && !pins.access_select_hi && !pins.program_voltage_pin
        && !pins.write_strobe_a_read_strobe_n == 1'b0 && pins.access_select_lo && pins.entry_select;
    wire stay_ok = pins.reset_in && !pins.program_store_enable && !pins.entry_select;
    wire protected_w = lock_q != otp_write_strobe_a_pkg::LOCK_RESET;
    wire active = state_q == otp_write_strobe_a_pkg::ST_ACTIVE;
    wire [1:0] sel = {pins.access_select_hi, pins.access_select_lo};
    wire [otp_write_strobe_a_pkg::ADDR_W-1:0] full_addr = {hi_addr_q, addr_port};
    wire read_on = active && !pins.write_strobe_a_read_strobe_n;
    // programming only on a write-strobe rise while high voltage mode was latched
    wire wr_pulse = active && wr_rise && vpp_mode_q && pins.write_strobe_a_read_strobe_n;
    wire [otp_write_strobe_a_pkg::VER_IDX_W-1:0] ver_idx = addr_port[otp_write_strobe_a_pkg::VER_IDX_W-1:0];
    wire [otp_write_strobe_a_pkg::DATA_W-1:0] ver_byte =
        (ver_idx == 2'h0) ? otp_write_strobe_a_pkg::VERSION_BYTE0 :
        (ver_idx == 2'h1) ? otp_write_strobe_a_pkg::VERSION_BYTE1 :
        (ver_idx == 2'h2) ? otp_write_strobe_a_pkg::VERSION_BYTE2 : otp_write_strobe_a_pkg::VERSION_BYTE3;
    wire [otp_write_strobe_a_pkg::DATA_W-1:0] lock_byte = {{(otp_write_strobe_a_pkg::DATA_W-otp_write_strobe_a_pkg::LOCK_W){1'b0}}, lock_q};
    wire [otp_write_strobe_a_pkg::DATA_W-1:0] rd_sel =
        (sel == otp_write_strobe_a_pkg::SEL_VERSION) ? ver_byte :
        (sel == otp_write_strobe_a_pkg::SEL_LOCK) ? lock_byte :
        (sel == otp_write_strobe_a_pkg::SEL_MEMORY) ? mem[full_addr] : otp_write_strobe_a_pkg::RESERVED_READ;

    always_comb begin
        state_d = state_q;
        case (state_q)
            otp_write_strobe_a_pkg::ST_IDLE: begin
                if (arm_ok) begin
                    state_d = otp_write_strobe_a_pkg::ST_ARMED;
                end
            end
            otp_write_strobe_a_pkg::ST_ARMED: begin
                if (!pins.reset_in) begin
                    state_d = otp_write_strobe_a_pkg::ST_IDLE;
                end else if (entry_fall) begin
                    state_d = otp_write_strobe_a_pkg::ST_ACTIVE;
                end
            end
            otp_write_strobe_a_pkg::ST_ACTIVE: begin
                // leaving with protection set closes the door for good
                if (!stay_ok) begin
                    state_d = protected_w ? otp_write_strobe_a_pkg::ST_LOCKED : otp_write_strobe_a_pkg::ST_IDLE;
                end
            end
            otp_write_strobe_a_pkg::ST_LOCKED: begin
                state_d = otp_write_strobe_a_pkg::ST_LOCKED;
            end
            default: begin
                state_d = otp_write_strobe_a_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= otp_write_strobe_a_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // write strobe and voltage role latched on the entry falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vpp_mode_q <= 1'b0;
        end else if (state_q == otp_write_strobe_a_pkg::ST_ARMED && entry_fall) begin
            vpp_mode_q <= 1'b1;
        end else if (state_d != otp_write_strobe_a_pkg::ST_ACTIVE) begin
            vpp_mode_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_addr_q <= '0;
        end else if (active && latch_fall) begin
            hi_addr_q <= addr_port[otp_write_strobe_a_pkg::HI_W-1:0];
        end
    end

    // lock bits can only be set, never cleared: written data is ORed into lock_q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= otp_write_strobe_a_pkg::LOCK_RESET;
        end else if (wr_pulse && sel == otp_write_strobe_a_pkg::SEL_LOCK) begin
            lock_q <= lock_q | data_in[otp_write_strobe_a_pkg::LOCK_W-1:0];
        end
    end

    // array not reset: lifetime contents, preset erased at its declaration
    always_ff @(posedge clk) begin
        if (wr_pulse && sel == otp_write_strobe_a_pkg::SEL_MEMORY) begin
            mem[full_addr] <= mem[full_addr] & data_in;
        end
    end

    // reads are registered, so data trails the address by one clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_sel;
        end
    end

    assign data_out = rd_data_q;
    assign data_oe = read_on;
    assign write_strobe_a_mode = active;
    assign prot_locked = protected_w;

    chk_oe_only_read: assert property (@(posedge clk) disable iff (!rst_n)
        data_oe |-> (!pins.write_strobe_a_read_strobe_n && state_q == otp_write_strobe_a_pkg::ST_ACTIVE))
        else $error("data port driven without read strobe");
    chk_high_addr_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (active && latch_fall) |=> hi_addr_q == $past(addr_port[otp_write_strobe_a_pkg::HI_W-1:0]))
        else $error("high address not latched on strobe fall");
    chk_locked_sticks: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == otp_write_strobe_a_pkg::ST_LOCKED |=> state_q == otp_write_strobe_a_pkg::ST_LOCKED)
        else $error("left locked state");
    chk_exit_protected: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !stay_ok && protected_w) |=> state_q == otp_write_strobe_a_pkg::ST_LOCKED)
        else $error("protected exit did not lock");
    chk_entry_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == otp_write_strobe_a_pkg::ST_ARMED && pins.reset_in && entry_fall) |=> active && vpp_mode_q)
        else $error("entry fall did not start programming mode");
    chk_lock_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_pulse && sel == otp_write_strobe_a_pkg::SEL_LOCK) |=>
        lock_q == ($past(lock_q) | $past(data_in[otp_write_strobe_a_pkg::LOCK_W-1:0])))
        else $error("lock bits not written");
    chk_read_version: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_VERSION && ver_idx == 2'h0) |=> rd_data_q == otp_write_strobe_a_pkg::VERSION_BYTE0)
        else $error("version read mismatch");
    chk_version_one: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_VERSION && ver_idx == 2'h1) |=> rd_data_q == otp_write_strobe_a_pkg::VERSION_BYTE1)
        else $error("version byte one mismatch");
    chk_version_two: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_VERSION && ver_idx == 2'h2) |=> rd_data_q == otp_write_strobe_a_pkg::VERSION_BYTE2)
        else $error("version byte two mismatch");
    chk_version_three: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_VERSION && ver_idx == 2'h3) |=> rd_data_q == otp_write_strobe_a_pkg::VERSION_BYTE3)
        else $error("version byte three mismatch");
    chk_reserved_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_RESERVED) |=> rd_data_q == otp_write_strobe_a_pkg::RESERVED_READ)
        else $error("reserved select read mismatch");
    chk_no_slave_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q != otp_write_strobe_a_pkg::ST_ACTIVE) |-> !data_oe ##1 (lock_q == $past(lock_q)))
        else $error("activity outside programming mode");
    chk_read_data: assert property (@(posedge clk) disable iff (!rst_n)
        (read_on && $stable(rd_sel)) |=> data_out == $past(rd_sel))
        else $error("read data not presented");
    chk_lock_read: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == otp_write_strobe_a_pkg::SEL_LOCK) |=> rd_data_q[otp_write_strobe_a_pkg::LOCK_W-1:0] == $past(lock_q))
        else $error("lock bits not presented");
    chk_mem_program: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_pulse && sel == otp_write_strobe_a_pkg::SEL_MEMORY) |=>
        mem[$past(full_addr)] == ($past(rd_sel) & $past(data_in)))
        else $error("memory byte not programmed");
    chk_exit_unprotected: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !stay_ok && !protected_w) |=> state_q == otp_write_strobe_a_pkg::ST_IDLE)
        else $error("unprotected exit did not return to idle");
    chk_write_needs_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (!active && wr_rise) |=> lock_q == $past(lock_q))
        else $error("lock bits changed outside programming mode");
    chk_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !(active && latch_fall) |=> $stable(hi_addr_q))
        else $error("high address changed without strobe fall");
    chk_stay_active: assert property (@(posedge clk) disable iff (!rst_n)
        (active && stay_ok) |=> active && vpp_mode_q)
        else $error("programming mode dropped while pins held");
    chk_refuse_locked: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == otp_write_strobe_a_pkg::ST_LOCKED) |-> !data_oe && !wr_pulse)
        else $error("locked device still accessible");
    chk_arm_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == otp_write_strobe_a_pkg::ST_IDLE && arm_ok) |=> state_q == otp_write_strobe_a_pkg::ST_ARMED)
        else $error("entry pins did not arm");
    cov_enter: cover property (@(posedge clk) disable iff (!rst_n) state_q == otp_write_strobe_a_pkg::ST_ARMED ##1 active);
    cov_lock_write: cover property (@(posedge clk) disable iff (!rst_n) wr_pulse && sel == otp_write_strobe_a_pkg::SEL_LOCK);
    cov_mem_write: cover property (@(posedge clk) disable iff (!rst_n) wr_pulse && sel == otp_write_strobe_a_pkg::SEL_MEMORY);
    cov_read: cover property (@(posedge clk) disable iff (!rst_n) read_on ##1 read_on);
    cov_locked: cover property (@(posedge clk) disable iff (!rst_n) state_q == otp_write_strobe_a_pkg::ST_LOCKED);
endmodule

// file: verif/otp_station_model.sv
// partner model: port 0 data bus shared by station and device
`timescale 1ns/1ps
module otp_station_model (
    input wire logic clk,
    input wire logic st_oe,
    input wire logic [7:0] st_data,
    input wire logic dev_oe,
    input wire logic [7:0] dev_data,
    output logic [7:0] bus
);
    logic [7:0] last_q = 8'h00;
    // a released bus never repeats its last value, so stale data cannot match
    always_comb begin
        if (st_oe) begin
            bus = st_data;
        end else if (dev_oe) begin
            bus = dev_data;
        end else begin
            bus = ~last_q;
        end
    end
    always_ff @(posedge clk) begin
        last_q <= bus;
    end
endmodule

// file: verif/otp_programming_port_tb.sv
// testbench: station drives the programming pins and judges port 0
`timescale 1ns/1ps
module otp_programming_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    otp_write_strobe_a_pkg::ctrl_pins_type pins = '0;
    logic [7:0] addr_port = 8'h00;
    logic [7:0] st_data = 8'h00;
    logic st_oe = 1'b0;
    logic [7:0] data_out;
    logic [7:0] bus;
    logic data_oe;
    logic write_strobe_a_mode;
    logic prot_locked;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    otp_programming_port u_dut (.clk(clk), .rst_n(rst_n), .pins(pins), .addr_port(addr_port),
        .data_in(bus), .data_out(data_out), .data_oe(data_oe), .write_strobe_a_mode(write_strobe_a_mode),
        .prot_locked(prot_locked));
    otp_station_model u_station (.clk(clk), .st_oe(st_oe), .st_data(st_data), .dev_oe(data_oe),
        .dev_data(data_out), .bus(bus));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic enter_mode;
        pins.program_store_enable = 1'b0;
        pins.write_strobe_a_n = 1'b0;
        pins.high_addr_latch_strobe = 1'b0;
        pins.access_select_hi = 1'b0;
        pins.program_voltage_pin = 1'b0;
        pins.write_strobe_a_read_strobe_n = 1'b1;
        pins.access_select_lo = 1'b1;
        pins.entry_select = 1'b1;
        tick(2);
        pins.entry_select = 1'b0;
        tick(3);
        pins.write_strobe_a_n = 1'b1;
        pins.program_voltage_pin = 1'b1;
        tick(2);
    endtask
    task automatic select(input logic [1:0] sel, input logic [5:0] hi);
        pins.high_addr_latch_strobe = 1'b0;
        {pins.access_select_hi, pins.access_select_lo} = sel;
        addr_port = {2'h0, hi};
        tick(1);
        pins.high_addr_latch_strobe = 1'b1;
        tick(1);
        pins.high_addr_latch_strobe = 1'b0;
        tick(1);
        // high address held over the edge that sees the strobe low
        addr_port = 8'hC3;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] lo, input logic [7:0] exp);
        addr_port = lo;
        pins.write_strobe_a_read_strobe_n = 1'b0;
        tick(2);
        check(bus, exp);
        pins.write_strobe_a_read_strobe_n = 1'b1;
        tick(1);
        check({7'h00, data_oe}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] lo, input logic [7:0] d);
        addr_port = lo;
        st_data = d;
        st_oe = 1'b1;
        tick(1);
        pins.write_strobe_a_n = 1'b0;
        tick(1);
        pins.write_strobe_a_n = 1'b1;
        tick(3);
        st_oe = 1'b0;
        tick(1);
    endtask
    task automatic test_idle;
        check({7'h00, write_strobe_a_mode}, 8'h00);
        select(otp_write_strobe_a_pkg::SEL_MEMORY, 6'h00);
        wr(8'h00, 8'h00);
        pins.write_strobe_a_read_strobe_n = 1'b0;
        tick(2);
        check({7'h00, data_oe}, 8'h00);
        enter_mode();
        check({7'h00, write_strobe_a_mode}, 8'h01);
    endtask
    task automatic test_version;
        logic [7:0] ver [4];
        ver = '{otp_write_strobe_a_pkg::VERSION_BYTE0, otp_write_strobe_a_pkg::VERSION_BYTE1,
            otp_write_strobe_a_pkg::VERSION_BYTE2, otp_write_strobe_a_pkg::VERSION_BYTE3};
        select(otp_write_strobe_a_pkg::SEL_VERSION, 6'h00);
        for (int i = 0; i < 4; i++) begin
            rd(8'(i), ver[i]);
        end
        select(otp_write_strobe_a_pkg::SEL_RESERVED, 6'h00);
        rd(8'h00, otp_write_strobe_a_pkg::RESERVED_READ);
    endtask
    task automatic test_memory;
        select(otp_write_strobe_a_pkg::SEL_MEMORY, 6'h3F);
        wr(8'hFF, 8'h3C);
        rd(8'hFF, 8'h3C);
        wr(8'hFF, 8'hF0);
        rd(8'hFF, 8'h30);
        select(otp_write_strobe_a_pkg::SEL_MEMORY, 6'h1F);
        rd(8'hFF, otp_write_strobe_a_pkg::ERASED_BYTE);
        select(otp_write_strobe_a_pkg::SEL_MEMORY, 6'h00);
        rd(8'h00, otp_write_strobe_a_pkg::ERASED_BYTE);
    endtask
    task automatic test_lock;
        select(otp_write_strobe_a_pkg::SEL_LOCK, 6'h00);
        check({7'h00, prot_locked}, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h01);
        check({7'h00, prot_locked}, 8'h01);
        rd(8'h00, 8'h01);
        pins.entry_select = 1'b1;
        tick(3);
        check({7'h00, write_strobe_a_mode}, 8'h00);
        enter_mode();
        check({7'h00, write_strobe_a_mode}, 8'h00);
        pins.write_strobe_a_read_strobe_n = 1'b0;
        tick(2);
        check({7'h00, data_oe}, 8'h00);
    endtask
    // unprotected exit must allow a fresh entry with the array intact
    task automatic test_reenter;
        pins.reset_in = 1'b0;
        tick(2);
        check({7'h00, write_strobe_a_mode}, 8'h00);
        pins.reset_in = 1'b1;
        enter_mode();
        check({7'h00, write_strobe_a_mode}, 8'h01);
        select(otp_write_strobe_a_pkg::SEL_MEMORY, 6'h3F);
        rd(8'hFF, 8'h30);
    endtask
    // hang guard: whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        pins.reset_in = 1'b1;
        pins.write_strobe_a_read_strobe_n = 1'b1;
        pins.write_strobe_a_n = 1'b1;
        tick(16);
        rst_n = 1'b1;
        tick(1);
        test_idle();
        test_version();
        test_memory();
        test_reenter();
        test_lock();
        end_sim();
    end
endmodule
